// ### rtl/rdac_pkg.sv
/*
  Constants for the discovery, lookup and association control block:
  register offsets, reset values, timing and frame codes.
  Assumes a 20 MHz system clock and a 32-bit classic Wishbone bus.
*/
`default_nettype none
package rdac_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_WAIT      = 8'h00;
  localparam logic [7:0] OFS_SURV_OPT  = 8'h04;
  localparam logic [7:0] OFS_ROLE      = 8'h08;
  localparam logic [7:0] OFS_LANE_MASK = 8'h0C;
  localparam logic [7:0] OFS_EXPONENT  = 8'h10;
  localparam logic [7:0] OFS_LEAF_OPT  = 8'h14;
  localparam logic [7:0] OFS_HUB_OPT   = 8'h18;
  localparam logic [7:0] OFS_TGT_LOW   = 8'h1C;
  localparam logic [7:0] OFS_TGT_HIGH  = 8'h20;
  localparam logic [7:0] OFS_LOCAL_MY  = 8'h24;
  localparam logic [7:0] OFS_CTRL      = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h2C;
  localparam logic [7:0] OFS_SCAN_TIME = 8'h30;
  localparam logic [7:0] OFS_RESP_MY   = 8'h34;
  localparam logic [7:0] OFS_RESP_HIGH = 8'h38;
  localparam logic [7:0] OFS_RESP_LOW  = 8'h3C;

  // value limits and reset values
  localparam logic [7:0]  WAIT_MIN      = 8'h01;
  localparam logic [7:0]  WAIT_MAX      = 8'hFC;
  localparam logic [7:0]  WAIT_RST      = 8'h19;
  localparam logic [15:0] LANE_MASK_RST = 16'h1FFE;
  localparam logic [15:0] LANE_HP_AVAIL = 16'h1FFE;
  localparam logic [3:0]  EXPONENT_RST  = 4'h4;
  localparam logic [7:0]  FIRST_LANE    = 8'h0B;
  localparam logic [15:0] NO_SHORT_ADDR = 16'hFFFE;
  localparam logic [15:0] SHORT_LIMIT   = 16'hFFFF;

  // field positions
  localparam int SELF_REPLY_BIT  = 1;
  localparam int CTRL_SURVEY     = 0;
  localparam int CTRL_LOOKUP     = 1;
  localparam int CTRL_LABEL_NONE = 2;
  localparam int CTRL_API        = 3;
  localparam int CTRL_ENTER_CMD  = 4;

  // frame type codes
  localparam logic [7:0] FRAME_LOCAL_REQ  = 8'h08;
  localparam logic [7:0] FRAME_LOCAL_RESP = 8'h88;

  // timing
  localparam longint CLK_HZ      = 20_000_000;
  localparam longint TICK_MS     = 100;
  localparam longint TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // scan time is kept in 10 us units
  localparam logic [31:0] SLOT_10US    = 32'h0000_0600;  // 15.36 ms
  localparam logic [31:0] LANE_OH_10US = 32'h0000_0ED8;  // 38 ms
  localparam logic [31:0] BASE_10US    = 32'h0000_07D0;  // 20 ms

  typedef enum logic [1:0] {RDAC_IDLE, RDAC_SURVEY, RDAC_LOOKUP} rdac_state_t;
endpackage
`default_nettype wire

// ### rtl/rdac_top.sv
/*
  Discovery, label lookup, role and association control of a radio node.
  Software reaches everything through a classic Wishbone slave; the radio
  side is logic on the same clock that reports peer responses.
*/
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rdac_top
  import rdac_pkg::*;
#(
  parameter longint TICK_LEN   = TICK_CYCLES,
  parameter bit     HIGH_POWER = 1'b0
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // radio side, same clock
  input  wire logic        peer_resp_i,
  input  wire logic        peer_label_match_i,
  input  wire logic [15:0] peer_short_i,
  input  wire logic [63:0] peer_long_i,
  input  wire logic        assoc_done_i,
  input  wire logic        pin_wake_i,
  output logic             survey_req_o,
  output logic      [7:0]  survey_wait_o,
  output logic             self_entry_o,
  output logic             resp_report_o,
  output logic      [15:0] lane_enable_o,
  output logic             use_short_addr_o,
  // association controls
  output logic             coordinator_o,
  output logic             any_tag_o,
  output logic             any_lane_o,
  output logic             assoc_attempt_o,
  output logic             poll_req_o,
  output logic             tag_survey_o,
  output logic             energy_survey_o,
  output logic             permit_assoc_o
);

  localparam logic [15:0] LANE_AVAIL = HIGH_POWER ? LANE_HP_AVAIL : 16'hFFFF;
  localparam logic [31:0] TICK_LAST  = 32'(TICK_LEN - 1);

  function automatic logic [4:0] count_lanes(input logic [15:0] m);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, m[i]};
    end
    return n;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  wait_limit, next_wait_limit;
  logic        self_reply, next_self_reply;
  logic        role, next_role;
  logic [15:0] lane_mask, next_lane_mask;
  logic [3:0]  exponent, next_exponent;
  logic [3:0]  leaf_opts, next_leaf_opts;
  logic [2:0]  hub_opts, next_hub_opts;
  logic [31:0] tgt_low, next_tgt_low;
  logic [31:0] tgt_high, next_tgt_high;
  logic [15:0] local_my, next_local_my;
  logic        api_mode, next_api_mode;
  logic        cmd_mode, next_cmd_mode;
  logic        res_ok, next_res_ok;
  logic        res_err, next_res_err;
  logic [7:0]  frame_type, next_frame_type;
  logic [7:0]  resp_count, next_resp_count;
  logic [15:0] resp_my, next_resp_my;
  logic [63:0] resp_long, next_resp_long;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [7:0]  tick_num, next_tick_num;
  logic [31:0] scan_time, next_scan_time;
  rdac_state_t state, next_state;
  logic        ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic        wake_s1, wake_s2, wake_d;

  ////////////////////////////////////////////////////////////////////////
  // bus decode and main control
  logic        wr, rd_sel, win_end;
  logic [31:0] ctrl_w, stat_w;

  always_comb begin
    wr      = cyc_i && stb_i && we_i && !ack;
    rd_sel  = cyc_i && stb_i && !ack;
    ctrl_w  = (wr && adr_i == OFS_CTRL && sel_i[0]) ? dat_i : 32'h0;
    stat_w  = {8'h00, resp_count, frame_type, 3'b000, res_err, res_ok,
               cmd_mode, state == RDAC_LOOKUP, state == RDAC_SURVEY};
    // window ends after wait_limit whole ticks
    win_end = tick_cnt == TICK_LAST && tick_num == wait_limit - 8'h01;

    next_wait_limit = wait_limit;
    next_self_reply = self_reply;
    next_role       = role;
    next_lane_mask  = lane_mask;
    next_exponent   = exponent;
    next_leaf_opts  = leaf_opts;
    next_hub_opts   = hub_opts;
    next_tgt_low    = tgt_low;
    next_tgt_high   = tgt_high;
    next_local_my   = local_my;
    next_api_mode   = api_mode;
    next_cmd_mode   = cmd_mode;
    next_res_ok     = res_ok;
    next_res_err    = res_err;
    next_frame_type = frame_type;
    next_resp_count = resp_count;
    next_resp_my    = resp_my;
    next_resp_long  = resp_long;
    next_tick_cnt   = tick_cnt;
    next_tick_num   = tick_num;
    next_state      = state;
    next_ack        = cyc_i && stb_i && !ack;
    next_rdata      = 32'h0;

    if (wr && sel_i[0]) begin
      unique case (adr_i)
        OFS_WAIT: begin
          if (dat_i[7:0] >= WAIT_MIN && dat_i[7:0] <= WAIT_MAX) begin
            next_wait_limit = dat_i[7:0];
          end
        end
        OFS_SURV_OPT:  next_self_reply = dat_i[SELF_REPLY_BIT];
        OFS_ROLE:      next_role = dat_i[0];
        OFS_EXPONENT:  next_exponent = dat_i[3:0];
        // reserved join bits are not stored
        OFS_LEAF_OPT:  next_leaf_opts = dat_i[3:0];
        OFS_HUB_OPT:   next_hub_opts = dat_i[2:0];
        default: ;
      endcase
    end
    if (wr) begin
      unique case (adr_i)
        OFS_LANE_MASK: next_lane_mask = 16'(merge_bytes({16'h0, lane_mask}, dat_i, sel_i)) & LANE_AVAIL;
        OFS_TGT_LOW:   next_tgt_low = merge_bytes(tgt_low, dat_i, sel_i);
        OFS_TGT_HIGH:  next_tgt_high = merge_bytes(tgt_high, dat_i, sel_i);
        OFS_LOCAL_MY:  next_local_my = 16'(merge_bytes({16'h0, local_my}, dat_i, sel_i));
        default: ;
      endcase
    end
    if (ctrl_w[CTRL_ENTER_CMD]) begin
      next_cmd_mode = 1'b1;
    end

    if (rd_sel && !we_i) begin
      unique case (adr_i)
        OFS_WAIT:      next_rdata = {24'h0, wait_limit};
        OFS_SURV_OPT:  next_rdata = {30'h0, self_reply, 1'b0};
        OFS_ROLE:      next_rdata = {31'h0, role};
        OFS_LANE_MASK: next_rdata = {16'h0, lane_mask};
        OFS_EXPONENT:  next_rdata = {28'h0, exponent};
        OFS_LEAF_OPT:  next_rdata = {28'h0, leaf_opts};
        OFS_HUB_OPT:   next_rdata = {29'h0, hub_opts};
        OFS_TGT_LOW:   next_rdata = tgt_low;
        OFS_TGT_HIGH:  next_rdata = tgt_high;
        OFS_LOCAL_MY:  next_rdata = {16'h0, local_my};
        OFS_CTRL:      next_rdata = {31'h0, api_mode};
        OFS_STATUS:    next_rdata = stat_w;
        OFS_SCAN_TIME: next_rdata = scan_time;
        OFS_RESP_MY:   next_rdata = {16'h0, resp_my};
        OFS_RESP_HIGH: next_rdata = resp_long[63:32];
        OFS_RESP_LOW:  next_rdata = resp_long[31:0];
        default:       next_rdata = 32'h0;
      endcase
    end

    unique case (state)
      RDAC_IDLE: begin
        next_tick_cnt = 32'h0;
        next_tick_num = 8'h00;
        if (ctrl_w[CTRL_SURVEY]) begin
          next_state      = RDAC_SURVEY;
          next_resp_count = {7'h00, self_reply};
          next_res_ok     = 1'b0;
          next_res_err    = 1'b0;
        end else if (ctrl_w[CTRL_LOOKUP]) begin
          next_api_mode = ctrl_w[CTRL_API];
          next_res_ok   = 1'b0;
          next_res_err  = 1'b0;
          // empty label fails at once, command mode kept
          if (ctrl_w[CTRL_LABEL_NONE]) begin
            next_res_err = 1'b1;
          end else begin
            next_state = RDAC_LOOKUP;
          end
        end
      end
      RDAC_SURVEY, RDAC_LOOKUP: begin
        next_tick_cnt = tick_cnt == TICK_LAST ? 32'h0 : tick_cnt + 32'h1;
        if (tick_cnt == TICK_LAST) begin
          next_tick_num = tick_num + 8'h01;
        end
        if (state == RDAC_SURVEY && peer_resp_i) begin
          next_resp_count = resp_count + 8'h01;
          next_resp_my    = peer_short_i;
          next_resp_long  = peer_long_i;
        end
        if (state == RDAC_LOOKUP && peer_resp_i && peer_label_match_i) begin
          next_state     = RDAC_IDLE;
          next_res_ok    = 1'b1;
          next_resp_my   = peer_short_i;
          next_resp_long = peer_long_i;
          // short form when the match has a usable short address
          if (peer_short_i < NO_SHORT_ADDR) begin
            next_tgt_high = 32'h0;
            next_tgt_low  = {16'h0, peer_short_i};
          end else begin
            next_tgt_high = peer_long_i[63:32];
            next_tgt_low  = peer_long_i[31:0];
          end
          // API answer carries both address forms
          // local request answered with response frame code
          if (api_mode) begin
            next_frame_type = FRAME_LOCAL_RESP;
          end else begin
            next_cmd_mode = 1'b0;
          end
        end else if (win_end) begin
          // late responses fall into idle and are dropped
          next_state = RDAC_IDLE;
          if (state == RDAC_LOOKUP) begin
            // timeout is an error, command mode kept
            next_res_err = 1'b1;
          end
        end
      end
      default: next_state = RDAC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_limit <= WAIT_RST;
      self_reply <= 1'b0;
      role       <= 1'b0;
      lane_mask  <= LANE_MASK_RST;
      exponent   <= EXPONENT_RST;
      leaf_opts  <= 4'h0;
      hub_opts   <= 3'h0;
      tgt_low    <= 32'h0;
      tgt_high   <= 32'h0;
      local_my   <= 16'h0;
      api_mode   <= 1'b0;
      cmd_mode   <= 1'b0;
      res_ok     <= 1'b0;
      res_err    <= 1'b0;
      frame_type <= FRAME_LOCAL_REQ;
      resp_count <= 8'h00;
      resp_my    <= 16'h0;
      resp_long  <= 64'h0;
      tick_cnt   <= 32'h0;
      tick_num   <= 8'h00;
      state      <= RDAC_IDLE;
      ack        <= 1'b0;
      rdata      <= 32'h0;
    end else begin
      wait_limit <= next_wait_limit;
      self_reply <= next_self_reply;
      role       <= next_role;
      lane_mask  <= next_lane_mask;
      exponent   <= next_exponent;
      leaf_opts  <= next_leaf_opts;
      hub_opts   <= next_hub_opts;
      tgt_low    <= next_tgt_low;
      tgt_high   <= next_tgt_high;
      local_my   <= next_local_my;
      api_mode   <= next_api_mode;
      cmd_mode   <= next_cmd_mode;
      res_ok     <= next_res_ok;
      res_err    <= next_res_err;
      frame_type <= next_frame_type;
      resp_count <= next_resp_count;
      resp_my    <= next_resp_my;
      resp_long  <= next_resp_long;
      tick_cnt   <= next_tick_cnt;
      tick_num   <= next_tick_num;
      state      <= next_state;
      ack        <= next_ack;
      rdata      <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan time and radio side outputs
  logic [4:0]  lanes;
  logic [31:0] next_scan;
  logic        next_survey_req, next_self_entry, next_report, next_poll;

  always_comb begin
    lanes = count_lanes(lane_mask);
    // lanes * (2^exp * 15.36 ms + 38 ms) + 20 ms
    next_scan = 32'({27'h0, lanes} * ((SLOT_10US << exponent) + LANE_OH_10US)) + BASE_10US;
    // wait limit sent with the request
    next_survey_req = state == RDAC_IDLE && (ctrl_w[CTRL_SURVEY] ||
                      (ctrl_w[CTRL_LOOKUP] && !ctrl_w[CTRL_LABEL_NONE]));
    // own entry added when self-reply set
    next_self_entry = state == RDAC_IDLE && ctrl_w[CTRL_SURVEY] && self_reply;
    next_report     = state == RDAC_SURVEY && peer_resp_i;
    // pin wake poll for an end device
    next_poll       = !role && leaf_opts[3] && wake_s2 && !wake_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_time        <= 32'h0;
      survey_req_o     <= 1'b0;
      survey_wait_o    <= WAIT_RST;
      self_entry_o     <= 1'b0;
      resp_report_o    <= 1'b0;
      lane_enable_o    <= LANE_MASK_RST;
      use_short_addr_o <= 1'b1;
      coordinator_o    <= 1'b0;
      any_tag_o        <= 1'b0;
      any_lane_o       <= 1'b0;
      assoc_attempt_o  <= 1'b0;
      poll_req_o       <= 1'b0;
      tag_survey_o     <= 1'b0;
      energy_survey_o  <= 1'b0;
      permit_assoc_o   <= 1'b0;
      wake_s1          <= 1'b0;
      wake_s2          <= 1'b0;
      wake_d           <= 1'b0;
    end else begin
      scan_time        <= next_scan;
      survey_req_o     <= next_survey_req;
      survey_wait_o    <= wait_limit;
      self_entry_o     <= next_self_entry;
      resp_report_o    <= next_report;
      // one mask gates all scan kinds
      lane_enable_o    <= lane_mask;
      use_short_addr_o <= tgt_high == 32'h0 && tgt_low < {16'h0, SHORT_LIMIT};
      coordinator_o    <= role;
      any_tag_o        <= !role && leaf_opts[0];
      any_lane_o       <= !role && leaf_opts[1];
      // retry until the link reports success
      assoc_attempt_o  <= !role && leaf_opts[2] && !assoc_done_i;
      poll_req_o       <= next_poll;
      // coordinator scans timed by exponent, see scan_time
      tag_survey_o     <= role && hub_opts[0];
      energy_survey_o  <= role && hub_opts[1];
      permit_assoc_o   <= role && hub_opts[2];
      wake_s1          <= pin_wake_i;
      wake_s2          <= wake_s1;
      wake_d           <= wake_s2;
    end
  end

  assign dat_o = rdata;
  assign ack_o = ack;

endmodule
`default_nettype wire

// ### dv/rdac_checker_properties.sv
/*
  Concurrent checks on the rdac_top ports, bound to every instance.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module rdac_checker
  import rdac_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        peer_resp_i,
  input wire logic        survey_req_o,
  input wire logic [7:0]  survey_wait_o,
  input wire logic        resp_report_o,
  input wire logic [15:0] lane_enable_o,
  input wire logic        coordinator_o,
  input wire logic        any_tag_o,
  input wire logic        assoc_attempt_o,
  input wire logic        tag_survey_o,
  input wire logic        permit_assoc_o,
  input wire logic        poll_req_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  sequence bus_req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ack_pulse_s;
    ack_o ##1 !ack_o;
  endsequence
  ack_single_a: assert property (bus_req_s |=> ack_pulse_s)
    else $error("ack not a single pulse one cycle after request");
  reset_values_a: assert property ($fell(rst_i) |-> survey_wait_o == WAIT_RST
    && lane_enable_o == LANE_MASK_RST && !coordinator_o) else $error("wrong value after reset");
  wait_range_a: assert property (survey_wait_o >= WAIT_MIN && survey_wait_o <= WAIT_MAX)
    else $error("wait limit out of range");
  req_cause_a: assert property (survey_req_o |-> (ack_o && we_i && adr_i == OFS_CTRL)
    ##1 !survey_req_o) else $error("survey request without control write");
  report_cause_a: assert property (resp_report_o |-> $past(peer_resp_i))
    else $error("report without peer response");
  lane_cause_a: assert property (!$stable(lane_enable_o) |-> $past(rst_i)
    || $past(ack_o && we_i && adr_i == OFS_LANE_MASK, 1)
    || $past(ack_o && we_i && adr_i == OFS_LANE_MASK, 2)) else $error("lane mask changed alone");
  leaf_role_a: assert property (coordinator_o |-> !any_tag_o && !assoc_attempt_o)
    else $error("leaf option active on coordinator");
  hub_role_a: assert property (!coordinator_o |-> !tag_survey_o && !permit_assoc_o)
    else $error("hub option active on end device");
  poll_pulse_a: assert property (poll_req_o |-> !coordinator_o ##1 !poll_req_o)
    else $error("poll request malformed");
endmodule
bind rdac_top rdac_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .peer_resp_i(peer_resp_i),
  .survey_req_o(survey_req_o), .survey_wait_o(survey_wait_o), .resp_report_o(resp_report_o),
  .lane_enable_o(lane_enable_o), .coordinator_o(coordinator_o), .any_tag_o(any_tag_o),
  .assoc_attempt_o(assoc_attempt_o), .tag_survey_o(tag_survey_o),
  .permit_assoc_o(permit_assoc_o), .poll_req_o(poll_req_o));
`default_nettype wire

// ### dv/rdac_peer_model.sv
/*
  Remote peer: answers each survey request with one response pulse.
  Assumes the bench sets delay, match and addresses before the request.
*/
`timescale 1ns/100ps
`default_nettype none
module rdac_peer_model #(
  parameter int TICK = 10
) (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [7:0]  wait_i,
  input  wire logic [15:0] delay_i,
  input  wire logic        match_i,
  input  wire logic [15:0] short_i,
  input  wire logic [63:0] long_i,
  output logic             resp_o,
  output logic             match_o,
  output logic      [15:0] short_o,
  output logic      [63:0] long_o
);
  int   cnt = 0;
  logic tog = 1'b0;
  always @(posedge clk_i) begin
    tog <= ~tog;
    resp_o <= (cnt == 1);
    if (req_i)
      cnt <= (delay_i != 16'h0000) ? int'(delay_i) : int'(wait_i) * TICK / 2;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // released lines toggle so stale values are never seen
  assign match_o = resp_o ? match_i : tog;
  assign short_o = resp_o ? short_i : {16{tog}};
  assign long_o  = resp_o ? long_i : {64{tog}};
endmodule
`default_nettype wire

// ### dv/tb.sv
/*
  Self-checking bench for rdac_top over classic Wishbone.
  Assumes a 20 MHz clock and a tick shortened to 10 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rdac_pkg::*;
  localparam int TL = 10;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        ack_o, p_resp, p_match, wake = 0, done = 0, mt = 0;
  logic [15:0] p_short, sh = 16'h0, dly = 16'h0, lane;
  logic [63:0] p_long, lg = 64'h0;
  logic        req, self, rep, shrt, coord, atag, alane, att, poll, tsv, esv, perm;
  logic [7:0]  swait;
  int          n_fail = 0, total_checks = 0, n_req = 0, n_rep = 0, n_poll = 0, n_self = 0;
  always #25 clk_i = ~clk_i;
  rdac_top #(.TICK_LEN(TL), .HIGH_POWER(1'b0)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .peer_resp_i(p_resp),
    .peer_label_match_i(p_match), .peer_short_i(p_short), .peer_long_i(p_long),
    .assoc_done_i(done), .pin_wake_i(wake), .survey_req_o(req), .survey_wait_o(swait),
    .self_entry_o(self), .resp_report_o(rep), .lane_enable_o(lane), .use_short_addr_o(shrt),
    .coordinator_o(coord), .any_tag_o(atag), .any_lane_o(alane), .assoc_attempt_o(att),
    .poll_req_o(poll), .tag_survey_o(tsv), .energy_survey_o(esv), .permit_assoc_o(perm));
  rdac_peer_model #(.TICK(TL)) peer (
    .clk_i(clk_i), .req_i(req), .wait_i(swait), .delay_i(dly), .match_i(mt), .short_i(sh),
    .long_i(lg), .resp_o(p_resp), .match_o(p_match), .short_o(p_short), .long_o(p_long));
  always @(posedge clk_i) begin
    n_req <= n_req + int'(req);
    n_rep <= n_rep + int'(rep);
    n_poll <= n_poll + int'(poll);
    n_self <= n_self + int'(self);
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic idle();
    do begin
      wb(1'b0, OFS_STATUS, 32'h0);
    end while (q[1:0] !== 2'b00);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic look(input logic [7:0] c, input logic [15:0] d, input logic m, input logic [2:0] e);
    dly <= d;
    mt <= m;
    wb(1'b1, OFS_CTRL, 32'h10);
    wb(1'b1, OFS_CTRL, {24'h0, c});
    idle();
    chk("err_ok_cmd", {29'h0, e}, {29'h0, q[4:2]});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  initial begin
    static logic [7:0]  wv[4] = '{8'h00, 8'hFD, 8'hFC, 8'h01};
    static logic [7:0]  wx[4] = '{8'h19, 8'h19, 8'hFC, 8'h01};
    static logic [15:0] mk[3] = '{16'h0003, 16'h1FFE, 16'hFFFF};
    static logic [3:0]  ex[3] = '{4'h0, 4'h4, 4'hF};
    static logic [15:0] dv[3] = '{16'd15, 16'd25, 16'd0};
    int          nr;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_WAIT, 32'h19, "wait");
    rd(OFS_LANE_MASK, 32'h1FFE, "mask");
    rd(OFS_EXPONENT, 32'h4, "exponent");
    rd(OFS_ROLE, 32'h0, "role");
    rd(OFS_STATUS, 32'h0800, "status");
    rd(8'hFC, 32'h0, "unmapped");
    $display("test reset done");
    foreach (wv[i]) begin
      wb(1'b1, OFS_WAIT, {24'h0, wv[i]});
      rd(OFS_WAIT, {24'h0, wx[i]}, "wait");
    end
    chk("wait_out", 32'h1, {24'h0, swait});
    $display("test wait range done");
    foreach (mk[i]) begin
      wb(1'b1, OFS_LANE_MASK, {16'h0, mk[i]});
      wb(1'b1, OFS_EXPONENT, {28'h0, ex[i]});
      rd(OFS_EXPONENT, {28'h0, ex[i]}, "exponent");
      nr = $countones(mk[i]);
      rd(OFS_SCAN_TIME, nr * (32'd1536 << ex[i]) + nr * 32'd3800 + 32'd2000, "scan");
      chk("lanes", {16'h0, mk[i]}, {16'h0, lane});
    end
    $display("test scan done");
    wb(1'b1, OFS_WAIT, 32'h2);
    wb(1'b1, OFS_SURV_OPT, 32'h2);
    foreach (dv[i]) begin
      dly <= dv[i];
      nr = n_rep;
      wb(1'b1, OFS_CTRL, 32'h1);
      idle();
      chk("reports", i == 1 ? 0 : 1, n_rep - nr);
      chk("count", i == 1 ? 32'h1 : 32'h2, {24'h0, q[23:16]});
    end
    chk("self_entries", 3, n_self);
    $display("test survey done");
    sh <= 16'h1234;
    look(8'h02, 16'd5, 1'b1, 3'b010);
    rd(OFS_TGT_LOW, 32'h1234, "tgt_low");
    rd(OFS_TGT_HIGH, 32'h0, "tgt_high");
    chk("short", 1, shrt);
    sh <= 16'hFFFE;
    lg <= 64'h0011_2233_4455_6677;
    look(8'h02, 16'd5, 1'b1, 3'b010);
    rd(OFS_TGT_HIGH, 32'h0011_2233, "tgt_high");
    rd(OFS_TGT_LOW, 32'h4455_6677, "tgt_low");
    chk("short", 0, shrt);
    look(8'h02, 16'd5, 1'b0, 3'b101);
    sh <= 16'h0042;
    lg <= 64'hA1B2_C3D4_E5F6_0718;
    look(8'h0A, 16'd5, 1'b1, 3'b011);
    rd(OFS_RESP_MY, 32'h42, "resp_my");
    rd(OFS_RESP_HIGH, 32'hA1B2_C3D4, "resp_high");
    rd(OFS_RESP_LOW, 32'hE5F6_0718, "resp_low");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("frame", 32'h88, {24'h0, q[15:8]});
    look(8'h0A, 16'd25, 1'b1, 3'b101);
    nr = n_req;
    look(8'h0E, 16'd5, 1'b1, 3'b101);
    chk("no_request", 0, n_req - nr);
    $display("test lookup done");
    wb(1'b1, OFS_LEAF_OPT, 32'hFF);
    rd(OFS_LEAF_OPT, 32'h0F, "leaf");
    chk("leaf_out", 32'h7, {29'h0, atag, alane, att});
    wake <= 1'b1;
    repeat (6) @(posedge clk_i);
    wake <= 1'b0;
    done <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("poll", 1, n_poll);
    chk("attempt_done", 0, att);
    done <= 1'b0;
    wb(1'b1, OFS_LEAF_OPT, 32'h3);
    rd(OFS_ROLE, 32'h0, "role");
    chk("attempt", 0, att);
    wb(1'b1, OFS_ROLE, 32'h1);
    wb(1'b1, OFS_HUB_OPT, 32'hFF);
    rd(OFS_HUB_OPT, 32'h07, "hub");
    chk("hub_out", 32'h1E, {27'h0, coord, tsv, esv, perm, atag});
    wb(1'b1, OFS_HUB_OPT, 32'h0);
    rd(OFS_ROLE, 32'h1, "role");
    chk("hub_off", 32'h10, {27'h0, coord, tsv, esv, perm, atag});
    $display("test options done");
    close_out();
  end
endmodule
`default_nettype wire
